/* File: hdl/sdr_pkg.sv */
// Shared constants and types for the synchronous DRAM device core.
package sdr_pkg;
   localparam int ROW_W = 12;
   localparam int COL_W = 9;
   localparam int BANK_W = 2;
   localparam int NBANK = 4;
   localparam int DATA_W = 8;
   localparam int MEM_ROW_BITS = 2;
   localparam int MEM_COL_BITS = 4;
   localparam int MEM_IDX_W = BANK_W + MEM_ROW_BITS + MEM_COL_BITS;
   localparam int MEM_DEPTH = 1 << MEM_IDX_W;

   // Mode register field layout.
   localparam int MR_BL_LSB = 0;
   localparam int MR_BT_BIT = 3;
   localparam int MR_CL_LSB = 4;
   localparam int MR_WB_BIT = 9;
   localparam int AP_BIT = 10;
   localparam logic [2:0] BL_1 = 3'h0;
   localparam logic [2:0] BL_2 = 3'h1;
   localparam logic [2:0] BL_4 = 3'h2;
   localparam logic [2:0] BL_8 = 3'h3;
   localparam logic [2:0] BL_FULL = 3'h7;
   localparam logic [2:0] CL_2 = 3'h2;
   localparam logic [2:0] CL_3 = 3'h3;
   localparam logic [ROW_W-1:0] MODE_RST = 12'h020;

   // Register map of the status slave.
   localparam int AXI_AW = 8;
   localparam logic [AXI_AW-1:0] REG_STATUS = 8'h00;
   localparam logic [AXI_AW-1:0] REG_MODE = 8'h04;
   localparam logic [AXI_AW-1:0] REG_REFCNT = 8'h08;
   localparam logic [AXI_AW-1:0] REG_SRINT = 8'h0c;
   localparam int ST_OPEN_LSB = 0;
   localparam int ST_PWR_LSB = 4;
   localparam int ST_BURST_BIT = 6;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Refresh timing.
   localparam int CLK_PERIOD_NS = 25;
   localparam int REF_WINDOW_NS = 64000000;
   localparam int REF_COUNT = 4096;
   localparam int REF_INTERVAL_CYC = REF_WINDOW_NS / REF_COUNT / CLK_PERIOD_NS;
   localparam logic [15:0] SRINT_RST = 16'(REF_INTERVAL_CYC);

   typedef enum logic [2:0] {
      CMD_NOP, CMD_ACT, CMD_RD, CMD_WR, CMD_PRE, CMD_REF, CMD_MRS, CMD_STOP
   } sdr_cmd_t;

   typedef enum logic [1:0] {
      PS_RUN, PS_POWER_DOWN, PS_SUSPEND, PS_SELF_REF
   } sdr_pwr_t;
endpackage

/* File: hdl/sdr_burst_if.sv */
// Link between the device core and its burst column generator.
`timescale 1ns/10ps
interface sdr_burst_if;
   logic load;
   logic step;
   logic interleave;
   logic [2:0] len_code;
   logic [8:0] start_col;
   logic [8:0] col;
   logic last;
   modport ctrl (output load, step, interleave, len_code, start_col,
                 input col, last);
   modport gen (input load, step, interleave, len_code, start_col,
                output col, last);
endinterface

/* File: hdl/sdr_burst_gen.sv */
// Burst column counter with sequential and interleaved ordering.
`timescale 1ns/10ps
module sdr_burst_gen
   import sdr_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   sdr_burst_if.gen bif
);
   typedef struct packed {
      logic [COL_W-1:0] start;
      logic [COL_W-1:0] cnt;
      logic [2:0] len;
      logic ilv;
   } sdr_bgen_t;

   sdr_bgen_t st_reg;
   sdr_bgen_t st_next;
   logic [COL_W-1:0] span;
   logic [COL_W-1:0] low;

   always_comb
   begin
      unique case (st_reg.len)
         BL_1: span = 9'h000;
         BL_2: span = 9'h001;
         BL_4: span = 9'h003;
         BL_8: span = 9'h007;
         default: span = 9'h1ff;
      endcase
      // Interleave has no meaning across a full row; it counts upward there.
      if (st_reg.ilv && span != 9'h1ff)
         low = st_reg.start ^ st_reg.cnt;
      else
         low = COL_W'(st_reg.start + st_reg.cnt);
      bif.col = (st_reg.start & ~span) | (low & span);
      bif.last = (span != 9'h1ff) && (st_reg.cnt == span);
      st_next = st_reg;
      if (bif.load)
      begin
         st_next.start = bif.start_col;
         st_next.cnt = 9'h001;
         st_next.len = bif.len_code;
         st_next.ilv = bif.interleave;
      end
      else if (bif.step)
         st_next.cnt = COL_W'(st_reg.cnt + 9'h001);
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         st_reg <= '0;
      else
         st_reg <= st_next;
   end
endmodule // sdr_burst_gen

/* File: hdl/sdr_device.sv */
// Synchronous DRAM device core with an AXI4-Lite status slave.
//
// Implementation choices: the register addresses and register access over AXI4-Lite.
`timescale 1ns/10ps
module sdr_device
   import sdr_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic clock_gate,
   input wire logic device_select_n,
   input wire logic row_strobe_n,
   input wire logic column_strobe_n,
   input wire logic write_strobe_n,
   input wire logic [BANK_W-1:0] bank_sel,
   input wire logic [ROW_W-1:0] addr_bus,
   input wire logic byte_mask,
   input wire logic [DATA_W-1:0] data_io_in,
   output logic [DATA_W-1:0] data_io_out,
   output logic data_io_oe,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [AXI_AW-1:0] s_axi_awaddr,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   output logic [1:0] s_axi_bresp,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   input wire logic [AXI_AW-1:0] s_axi_araddr,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp
);
   typedef struct packed {
      logic [ROW_W-1:0] mode;
      logic [NBANK-1:0] open;
      logic [NBANK-1:0][ROW_W-1:0] row;
      logic burst_on;
      logic burst_wr;
      logic [BANK_W-1:0] burst_bank;
      logic burst_ap;
      logic [2:0] pipe_v;
      logic [2:0][DATA_W-1:0] pipe_d;
      logic [1:0] dqm_sh;
      logic [DATA_W-1:0] dout;
      logic doe;
      sdr_pwr_t pwr;
      logic [15:0] sr_cnt;
      logic [15:0] ref_cnt;
      logic [15:0] srint;
      logic [MEM_DEPTH-1:0][DATA_W-1:0] mem;
      logic aw_have;
      logic [AXI_AW-1:0] aw_addr;
      logic w_have;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } sdr_state_t;

   sdr_state_t st_reg;
   sdr_state_t st_next;
   sdr_cmd_t cmd;
   logic run;
   logic beat_go;
   logic beat_wr;
   logic [BANK_W-1:0] beat_bank;
   logic [COL_W-1:0] beat_col;
   logic [MEM_IDX_W-1:0] beat_idx;
   logic [2:0] len;

   sdr_burst_if bif ();

   sdr_burst_gen u_burst_gen (
      .clk(clk),
      .rst(rst),
      .bif(bif)
   );

   always_comb
   begin
      st_next = st_reg;
      cmd = CMD_NOP;
      run = (st_reg.pwr == PS_RUN) && clock_gate;
      len = st_reg.mode[MR_BL_LSB +: 3];
      beat_go = 1'b0;
      beat_wr = st_reg.burst_wr;
      beat_bank = st_reg.burst_bank;
      beat_col = bif.col;
      bif.load = 1'b0;
      bif.step = 1'b0;
      bif.start_col = addr_bus[COL_W-1:0];
      bif.len_code = len;
      bif.interleave = st_reg.mode[MR_BT_BIT];

      if (!device_select_n)
      begin
         unique case ({row_strobe_n, column_strobe_n, write_strobe_n})
            3'b011: cmd = CMD_ACT;
            3'b101: cmd = CMD_RD;
            3'b100: cmd = CMD_WR;
            3'b010: cmd = CMD_PRE;
            3'b001: cmd = CMD_REF;
            3'b000: cmd = CMD_MRS;
            3'b110: cmd = CMD_STOP;
            3'b111: cmd = CMD_NOP;
         endcase
      end

      // Power state follows the clock gate.
      unique case (st_reg.pwr)
         PS_RUN:
         begin
            if (!clock_gate)
            begin
               if (cmd == CMD_REF && st_reg.open == '0 && !st_reg.burst_on)
               begin
                  st_next.pwr = PS_SELF_REF;
                  st_next.sr_cnt = 16'h0000;
               end
               else if (st_reg.burst_on || st_reg.pipe_v != 3'h0)
                  st_next.pwr = PS_SUSPEND;
               else
                  st_next.pwr = PS_POWER_DOWN;
            end
         end
         PS_SELF_REF:
         begin
            if (clock_gate)
               st_next.pwr = PS_RUN;
            else if (st_reg.sr_cnt == 16'(st_reg.srint - 16'h0001))
            begin
               st_next.sr_cnt = 16'h0000;
               st_next.ref_cnt = 16'(st_reg.ref_cnt + 16'h0001);
            end
            else
               st_next.sr_cnt = 16'(st_reg.sr_cnt + 16'h0001);
         end
         PS_POWER_DOWN, PS_SUSPEND:
         begin
            if (clock_gate)
               st_next.pwr = PS_RUN;
         end
      endcase

      // Nothing but the power state, its self-refresh counting of ref_cnt and the AXI4-Lite slave advances while the clock is gated.
      if (run)
      begin
         st_next.dqm_sh = {st_reg.dqm_sh[0], byte_mask};
         st_next.pipe_v = {st_reg.pipe_v[1:0], 1'b0};
         st_next.pipe_d = {st_reg.pipe_d[1:0], 8'h00};
         if (st_reg.mode[MR_CL_LSB +: 3] == CL_3)
         begin
            st_next.dout = st_reg.pipe_d[2];
            st_next.doe = st_reg.pipe_v[2] && !st_reg.dqm_sh[1];
         end
         else
         begin
            st_next.dout = st_reg.pipe_d[1];
            st_next.doe = st_reg.pipe_v[1] && !st_reg.dqm_sh[1];
         end

         if (st_reg.burst_on && (cmd == CMD_NOP || cmd == CMD_ACT))
         begin
            beat_go = 1'b1;
            bif.step = 1'b1;
            if (bif.last)
            begin
               st_next.burst_on = 1'b0;
               if (st_reg.burst_ap)
                  st_next.open[st_reg.burst_bank] = 1'b0;
            end
         end

         unique case (cmd)
            CMD_ACT:
            begin
               st_next.open[bank_sel] = 1'b1;
               st_next.row[bank_sel] = addr_bus;
            end
            CMD_RD, CMD_WR:
            begin
               beat_go = 1'b1;
               beat_wr = (cmd == CMD_WR);
               beat_bank = bank_sel;
               beat_col = addr_bus[COL_W-1:0];
               bif.load = 1'b1;
               st_next.burst_wr = beat_wr;
               st_next.burst_bank = bank_sel;
               st_next.burst_ap = addr_bus[AP_BIT];
               st_next.burst_on = (len != BL_1)
                  && !(beat_wr && st_reg.mode[MR_WB_BIT]);
               if (!st_next.burst_on && addr_bus[AP_BIT])
                  st_next.open[bank_sel] = 1'b0;
            end
            CMD_PRE:
            begin
               if (addr_bus[AP_BIT])
               begin
                  st_next.open = '0;
                  st_next.burst_on = 1'b0;
               end
               else
               begin
                  st_next.open[bank_sel] = 1'b0;
                  if (bank_sel == st_reg.burst_bank)
                     st_next.burst_on = 1'b0;
               end
            end
            CMD_REF: st_next.ref_cnt = 16'(st_reg.ref_cnt + 16'h0001);
            CMD_MRS: st_next.mode = addr_bus;
            CMD_STOP: st_next.burst_on = 1'b0;
            CMD_NOP: ;
         endcase
      end

      // Storage keeps all bank bits and a few low row and column bits; others alias.
      beat_idx = {beat_bank, st_reg.row[beat_bank][MEM_ROW_BITS-1:0],
                  beat_col[MEM_COL_BITS-1:0]};
      if (run && beat_go && beat_wr && !byte_mask)
         st_next.mem[beat_idx] = data_io_in;
      if (run && beat_go && !beat_wr)
      begin
         st_next.pipe_v[0] = 1'b1;
         st_next.pipe_d[0] = st_reg.mem[beat_idx];
      end

      // AXI4-Lite write: address and data are taken in either order.
      if (s_axi_awvalid && st_reg.awready)
      begin
         st_next.aw_have = 1'b1;
         st_next.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && st_reg.wready)
      begin
         st_next.w_have = 1'b1;
         st_next.w_data = s_axi_wdata;
         st_next.w_strb = s_axi_wstrb;
      end
      if (st_reg.bvalid && s_axi_bready)
         st_next.bvalid = 1'b0;
      if (st_next.aw_have && st_next.w_have && !st_reg.bvalid)
      begin
         st_next.aw_have = 1'b0;
         st_next.w_have = 1'b0;
         st_next.bvalid = 1'b1;
         st_next.bresp = RESP_SLVERR;
         if (st_next.aw_addr == REG_SRINT)
         begin
            st_next.bresp = RESP_OKAY;
            if (st_next.w_strb[0])
               st_next.srint[7:0] = st_next.w_data[7:0];
            if (st_next.w_strb[1])
               st_next.srint[15:8] = st_next.w_data[15:8];
         end
      end
      st_next.awready = !st_next.aw_have && !st_next.bvalid;
      st_next.wready = !st_next.w_have && !st_next.bvalid;

      // AXI4-Lite read.
      if (st_reg.rvalid && s_axi_rready)
      begin
         st_next.rvalid = 1'b0;
         st_next.arready = 1'b1;
      end
      if (s_axi_arvalid && st_reg.arready)
      begin
         st_next.arready = 1'b0;
         st_next.rvalid = 1'b1;
         st_next.rresp = RESP_OKAY;
         st_next.rdata = 32'h00000000;
         unique case (s_axi_araddr)
            REG_STATUS:
            begin
               st_next.rdata[ST_OPEN_LSB +: NBANK] = st_reg.open;
               st_next.rdata[ST_PWR_LSB +: 2] = st_reg.pwr;
               st_next.rdata[ST_BURST_BIT] = st_reg.burst_on;
            end
            REG_MODE: st_next.rdata[ROW_W-1:0] = st_reg.mode;
            REG_REFCNT: st_next.rdata[15:0] = st_reg.ref_cnt;
            REG_SRINT: st_next.rdata[15:0] = st_reg.srint;
            default: st_next.rresp = RESP_SLVERR;
         endcase
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         st_reg <= '0;
         st_reg.mode <= MODE_RST;
         st_reg.srint <= SRINT_RST;
         st_reg.awready <= 1'b1;
         st_reg.wready <= 1'b1;
         st_reg.arready <= 1'b1;
      end
      else
         st_reg <= st_next;
   end

   assign data_io_out = st_reg.dout;
   assign data_io_oe = st_reg.doe;
   assign s_axi_awready = st_reg.awready;
   assign s_axi_wready = st_reg.wready;
   assign s_axi_bvalid = st_reg.bvalid;
   assign s_axi_bresp = st_reg.bresp;
   assign s_axi_arready = st_reg.arready;
   assign s_axi_rvalid = st_reg.rvalid;
   assign s_axi_rdata = st_reg.rdata;
   assign s_axi_rresp = st_reg.rresp;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   AST_READ_CL2: assert property (
      (run && cmd == CMD_RD && !byte_mask
         && st_reg.mode[MR_CL_LSB +: 3] == CL_2)
      ##1 (run && cmd != CMD_MRS) ##1 run |=> data_io_oe)
      else $error("First read data missing two cycles after read.");
   AST_READ_CL3: assert property (
      (run && cmd == CMD_RD && st_reg.mode[MR_CL_LSB +: 3] == CL_3)
      ##1 (run && !byte_mask && cmd != CMD_MRS)
      ##1 (run && cmd != CMD_MRS) ##1 run |=> data_io_oe)
      else $error("First read data missing three cycles after read.");
   AST_READ_MASK: assert property (
      (run && byte_mask) ##1 run ##1 run |=> !data_io_oe)
      else $error("Data pins driven two cycles after read mask.");
   AST_WRITE_MASK: assert property (
      run && beat_go && beat_wr && byte_mask |=> $stable(st_reg.mem))
      else $error("Masked write changed storage.");
   AST_WRITE_DATA: assert property (
      run && beat_go && beat_wr && !byte_mask
      |=> st_reg.mem[$past(beat_idx)] == $past(data_io_in))
      else $error("Write data not stored from the sampled edge.");
   AST_CS_IGNORE: assert property (
      run && device_select_n |=> $stable(st_reg.mode) && $stable(st_reg.row))
      else $error("Command acted on while deselected.");
   AST_ACTIVATE: assert property (
      run && cmd == CMD_ACT |=> st_reg.open[$past(bank_sel)]
         && st_reg.row[$past(bank_sel)] == $past(addr_bus))
      else $error("Activate did not open the selected bank row.");
   AST_SELF_REF: assert property (
      st_reg.pwr == PS_RUN && !clock_gate && cmd == CMD_REF
      && st_reg.open == '0 && !st_reg.burst_on
      |=> st_reg.pwr == PS_SELF_REF)
      else $error("Self refresh not entered.");
   AST_SUSPEND: assert property (
      st_reg.pwr == PS_SUSPEND && !clock_gate |=> $stable(data_io_out)
         && $stable(data_io_oe) && $stable(st_reg.burst_on))
      else $error("Burst moved during clock suspend.");
   AST_PRE_ALL: assert property (
      run && cmd == CMD_PRE && addr_bus[AP_BIT] |=> st_reg.open == '0)
      else $error("Precharge all left a bank open.");
   AST_BURST4: assert property (
      (run && cmd == CMD_RD && len == BL_4)
      ##1 (run && cmd == CMD_NOP)[*3] |-> st_reg.burst_on ##1 !st_reg.burst_on)
      else $error("Burst of four did not end after four beats.");

   COV_READ_CL3: cover property (
      (run && cmd == CMD_RD && st_reg.mode[MR_CL_LSB +: 3] == CL_3)
      ##3 data_io_oe);
   COV_SELF_REF: cover property (
      st_reg.pwr == PS_SELF_REF ##1 st_reg.pwr == PS_RUN);
   COV_MASKED_BURST_WRITE: cover property (
      run && beat_go && beat_wr && st_reg.burst_on && byte_mask);
endmodule // sdr_device

/* File: verif/sdr_ctl_model.sv */
// Behavioural memory controller that drives the device's command pins.
`timescale 1ns/10ps
module sdr_ctl_model
   import sdr_pkg::*;
(
   input wire logic clk,
   output logic clock_gate,
   output logic device_select_n,
   output logic row_strobe_n,
   output logic column_strobe_n,
   output logic write_strobe_n,
   output logic [BANK_W-1:0] bank_sel,
   output logic [ROW_W-1:0] addr_bus,
   output logic byte_mask,
   input wire logic [DATA_W-1:0] data_io_out,
   input wire logic data_io_oe,
   output logic [DATA_W-1:0] data_io_in
);
   logic [DATA_W-1:0] wd_reg;
   logic [DATA_W-1:0] last_reg;
   logic drive_reg;

   // A released data bus shows the inverse of its last level.
   assign data_io_in = data_io_oe ? data_io_out :
      (drive_reg ? wd_reg : ~last_reg);

   initial
   begin
      clock_gate = 1'b1;
      device_select_n = 1'b1;
      {row_strobe_n, column_strobe_n, write_strobe_n} = 3'h7;
      bank_sel = 2'h0;
      addr_bus = 12'h000;
      byte_mask = 1'b0;
      wd_reg = 8'h00;
      drive_reg = 1'b0;
      last_reg = 8'h00;
   end

   always @(posedge clk)
      last_reg <= data_io_in;

   // Presents one command right after an edge and holds it for one edge.
   task automatic cmd(input logic [2:0] c, input logic [1:0] b = 2'h0,
      input logic [11:0] a = 12'h000, input logic [7:0] d = 8'h00,
      input logic dv = 1'b0, input logic m = 1'b0, input logic cs_n = 1'b0);
      {row_strobe_n, column_strobe_n, write_strobe_n} <= c;
      device_select_n <= cs_n;
      bank_sel <= b;
      addr_bus <= a;
      wd_reg <= d;
      drive_reg <= dv;
      byte_mask <= m;
      @(posedge clk);
   endtask
endmodule // sdr_ctl_model

/* File: verif/test_sdram_four_bank_cmd_interface.sv */
// Self-checking bench for the synchronous DRAM device core.
`timescale 1ns/10ps
module test_sdram_four_bank_cmd_interface
   import sdr_pkg::*;
;
   localparam logic [2:0] NOP = 3'h7, ACT = 3'h3, RD = 3'h5, WR = 3'h4;
   localparam logic [2:0] PRE = 3'h2, REF = 3'h1, MRS = 3'h0, STP = 3'h6;
   typedef struct {logic [11:0] mode; logic [11:0] col; int cl; int n;
      logic [63:0] e;} sdr_row_t;
   sdr_row_t rows[6] = '{
      '{12'h022, 12'h005, 2, 4, 64'h45464744_00000000},
      '{12'h03a, 12'h005, 3, 4, 64'h45444746_00000000},
      '{12'h023, 12'h00b, 2, 8, 64'h4b4c4d4e_4f48494a},
      '{12'h031, 12'h003, 3, 2, 64'h43420000_00000000},
      '{12'h020, 12'h009, 2, 1, 64'h49000000_00000000},
      '{12'h02b, 12'h00a, 2, 8, 64'h4a4b4849_4e4f4c4d}};
   logic clk, rst, clock_gate, device_select_n, byte_mask;
   logic row_strobe_n, column_strobe_n, write_strobe_n;
   logic [BANK_W-1:0] bank_sel;
   logic [ROW_W-1:0] addr_bus;
   logic [DATA_W-1:0] data_io_in, data_io_out;
   logic data_io_oe, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
   logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
   logic s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [AXI_AW-1:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, rr;
   int n_fail = 0;
   int num_checks = 0;

   sdr_device DUT (.clk, .rst, .clock_gate, .device_select_n, .row_strobe_n,
      .column_strobe_n, .write_strobe_n, .bank_sel, .addr_bus, .byte_mask,
      .data_io_in, .data_io_out, .data_io_oe, .s_axi_awvalid, .s_axi_awready,
      .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
      .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
      .s_axi_rdata, .s_axi_rresp);

   sdr_ctl_model ctl (.clk, .clock_gate, .device_select_n, .row_strobe_n,
      .column_strobe_n, .write_strobe_n, .bank_sel, .addr_bus, .byte_mask,
      .data_io_out, .data_io_oe, .data_io_in);

   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   task automatic stop_test();
      $display("Checks %0d, mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic chk(input logic ok, input string msg);
      num_checks++;
      if (ok !== 1'b1)
      begin
         n_fail++;
         $display("MISMATCH at %0t: %s", $time, msg);
      end
   endtask

   task automatic ax_wr(input logic [7:0] a, input logic [31:0] d,
      input logic [1:0] er);
      int k;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (k = 0; k < 50; k++)
      begin
         @(posedge clk);
         if (s_axi_awready === 1'b1)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1)
            s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid === 1'b1)
            break;
      end
      chk(k < 50 && s_axi_bresp === er, "register write response");
      if (k == 50)
         stop_test();
      s_axi_bready <= 1'b0;
      @(posedge clk);
   endtask

   task automatic ax_rd(input logic [7:0] a);
      int k;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (k = 0; k < 50; k++)
      begin
         @(posedge clk);
         if (s_axi_arready === 1'b1)
            s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid === 1'b1)
            break;
      end
      rd = s_axi_rdata;
      rr = s_axi_rresp;
      chk(k < 50, "register read timeout");
      if (k == 50)
         stop_test();
      s_axi_rready <= 1'b0;
      @(posedge clk);
   endtask

   task automatic reg_is(input logic [7:0] a, input logic [31:0] e,
      input logic [1:0] er);
      ax_rd(a);
      chk(rd === e && rr === er, "register read value");
   endtask

   // Checks n beats, one per edge, then the released bus; z marks floats.
   task automatic expect_rd(input int w, input logic [63:0] e, input int n,
      input logic [7:0] z = 8'h00);
      repeat (w) @(posedge clk);
      for (int i = 0; i <= n; i++)
      begin
         @(negedge clk);
         if (i == n || z[i])
            chk(data_io_oe === 1'b0, "data pins not released");
         else
            chk(data_io_oe === 1'b1 && data_io_out === e[63-8*i -: 8],
               "read beat");
         @(posedge clk);
      end
   endtask

   // Closes all banks, loads the mode and opens bank 1 row 2 with margins.
   task automatic setup(input logic [11:0] mode);
      ctl.cmd(PRE, 2'h0, 12'h400);
      ctl.cmd(NOP);
      ctl.cmd(NOP);
      ctl.cmd(MRS, 2'h0, mode);
      ctl.cmd(NOP);
      ctl.cmd(ACT, 2'h1, 12'h002);
      ctl.cmd(NOP);
      ctl.cmd(NOP);
   endtask

   initial
   begin
      rst = 1'b1;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
      {s_axi_arvalid, s_axi_rready} = 2'h0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
      s_axi_wstrb = 4'hf;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      reg_is(REG_MODE, 32'h20, RESP_OKAY);
      reg_is(REG_SRINT, 32'h271, RESP_OKAY);
      reg_is(REG_STATUS, 32'h0, RESP_OKAY);
      reg_is(8'h10, 32'h0, RESP_SLVERR);
      ax_wr(REG_MODE, 32'h23, RESP_SLVERR);
      reg_is(REG_MODE, 32'h20, RESP_OKAY);
      setup(12'h020);
      for (int c = 0; c < 16; c++)
         ctl.cmd(WR, 2'h1, 12'(c), 8'h40 + 8'(c), 1'b1);
      ctl.cmd(NOP);
      reg_is(REG_STATUS, 32'h2, RESP_OKAY);
      foreach (rows[i])
      begin
         setup(rows[i].mode);
         ctl.cmd(RD, 2'h1, rows[i].col);
         ctl.cmd(NOP);
         expect_rd(rows[i].cl - 1, rows[i].e, rows[i].n);
      end
      setup(12'h022);
      ctl.cmd(RD, 2'h1, 12'h000);
      ctl.cmd(RD, 2'h1, 12'h008);
      ctl.cmd(NOP);
      expect_rd(0, 64'h4048494a_4b000000, 5);
      ctl.cmd(RD, 2'h1, 12'h004);
      ctl.cmd(RD, 2'h1, 12'h00c, 8'h00, 1'b0, 1'b0, 1'b1);
      ctl.cmd(NOP);
      expect_rd(0, 64'h44454647_00000000, 4);
      ctl.cmd(RD, 2'h1, 12'h000);
      ctl.cmd(NOP, 2'h0, 12'h000, 8'h00, 1'b0, 1'b1);
      ctl.cmd(NOP);
      expect_rd(0, 64'h40414243_00000000, 4, 8'h02);
      ctl.cmd(WR, 2'h1, 12'h000, 8'h90, 1'b1);
      ctl.cmd(NOP, 2'h0, 12'h000, 8'h91, 1'b1, 1'b1);
      ctl.cmd(NOP, 2'h0, 12'h000, 8'h92, 1'b1);
      ctl.cmd(NOP, 2'h0, 12'h000, 8'h93, 1'b1);
      ctl.cmd(NOP);
      ctl.cmd(RD, 2'h1, 12'h000);
      ctl.cmd(NOP);
      expect_rd(1, 64'h90419293_00000000, 4);
      setup(12'h222);
      ctl.cmd(WR, 2'h1, 12'h004, 8'ha0, 1'b1);
      ctl.cmd(NOP, 2'h0, 12'h000, 8'ha1, 1'b1);
      ctl.cmd(NOP);
      ctl.cmd(RD, 2'h1, 12'h004);
      ctl.cmd(NOP);
      expect_rd(1, 64'ha0454647_00000000, 4);
      // Gating the clock mid-burst suspends it; it resumes where it stopped.
      ctl.cmd(RD, 2'h1, 12'h004);
      ctl.clock_gate <= 1'b0;
      ctl.cmd(NOP);
      reg_is(REG_STATUS, 32'h62, RESP_OKAY);
      ctl.clock_gate <= 1'b1;
      expect_rd(3, 64'ha0454647_00000000, 4);
      reg_is(REG_STATUS, 32'h2, RESP_OKAY);
      ctl.cmd(PRE, 2'h1);
      ctl.cmd(NOP);
      reg_is(REG_STATUS, 32'h0, RESP_OKAY);
      ctl.cmd(ACT, 2'h1, 12'h002);
      ctl.cmd(NOP);
      ctl.cmd(NOP);
      ctl.cmd(RD, 2'h1, 12'h400);
      ctl.cmd(NOP);
      expect_rd(1, 64'h90419293_00000000, 4);
      reg_is(REG_STATUS, 32'h0, RESP_OKAY);
      ctl.cmd(REF);
      repeat (3) ctl.cmd(NOP);
      ctl.cmd(REF);
      ctl.cmd(NOP);
      reg_is(REG_REFCNT, 32'h2, RESP_OKAY);
      ax_wr(REG_SRINT, 32'h4, RESP_OKAY);
      ctl.clock_gate <= 1'b0;
      ctl.cmd(REF);
      ctl.cmd(NOP);
      repeat (40) @(posedge clk);
      reg_is(REG_STATUS, 32'h30, RESP_OKAY);
      ax_rd(REG_REFCNT);
      chk(rd > 32'h4, "self refresh ticks");
      ctl.clock_gate <= 1'b1;
      repeat (3) @(posedge clk);
      reg_is(REG_STATUS, 32'h0, RESP_OKAY);
      ctl.cmd(ACT, 2'h0, 12'h000);
      ctl.cmd(NOP);
      ctl.clock_gate <= 1'b0;
      ctl.cmd(PRE, 2'h0, 12'h400);
      ctl.cmd(NOP);
      repeat (3) @(posedge clk);
      reg_is(REG_STATUS, 32'h11, RESP_OKAY);
      ctl.clock_gate <= 1'b1;
      repeat (3) @(posedge clk);
      reg_is(REG_STATUS, 32'h1, RESP_OKAY);
      // A full-row burst runs on until a burst stop ends it.
      setup(12'h027);
      ctl.cmd(RD, 2'h1, 12'h00e);
      ctl.cmd(NOP);
      ctl.cmd(STP);
      expect_rd(0, 64'h4e4f0000_00000000, 2);
      reg_is(REG_STATUS, 32'h2, RESP_OKAY);
      stop_test();
   end
endmodule // test_sdram_four_bank_cmd_interface
